// ==== common/mesm_defs.svh ====
// Constants for the monitor error status and masking block
`ifndef MESM_DEFS_SVH
`define MESM_DEFS_SVH
// Register offsets (byte addresses)
`define MESM_A_CFG        8'h00
`define MESM_A_STCTL      8'h04
`define MESM_A_SLEEP      8'h08
`define MESM_A_SLPMSK     8'h0c
`define MESM_A_GPIMSK     8'h10
`define MESM_A_MISCMSK    8'h14
`define MESM_A_MST_LO     8'h20
`define MESM_A_MST_HI     8'h24
`define MESM_A_HST_LO     8'h28
`define MESM_A_HST_HI     8'h2c
`define MESM_A_VLIM       8'h40
`define MESM_A_TLIM       8'h44
`define MESM_A_TACHLIM    8'h48
`define MESM_A_USRLIM     8'h4c
`define MESM_A_CHSEL      8'h50
`define MESM_A_VALUE      8'h80
// Field positions
`define MESM_B_ALERT_EN   0
`define MESM_B_ASF        0
// Masking values and reset defaults
`define MESM_VMASK        8'hff
`define MESM_TMASK        8'h80
`define MESM_FMASK        8'hff
`define MESM_SLEEP_DEEP   3'h5
`define MESM_SLEEP_RST    3'h0
// Timing
`define MESM_CLK_MHZ      100
`define MESM_PASS_MS      100
`define MESM_EXTRST_US    10
`endif

// ==== common/mesm_pkg.sv ====
// Types for the monitor error status and masking block
package mesm_pkg;
  typedef enum logic [1:0]
  {
    MESM_IDLE = 2'b00,
    MESM_CONV = 2'b01,
    MESM_POST = 2'b10
  } mesm_seq_t;
  // One posted conversion result
  typedef struct packed
  {
    logic       valid;
    logic [4:0] chan;
    logic [7:0] data;
  } mesm_result_t;
endpackage

// ==== logic/mesm_sequencer.sv ====
// Round-robin conversion sequencer
`timescale 1ns/10ps
`include "mesm_defs.svh"
module mesm_sequencer
  import mesm_pkg::*;
#(
  parameter int CONV_CYCLES = 40000
)
(
  input  wire logic         clk_sys_in,
  input  wire logic         resetn_in,
  input  wire logic [3:0]   sel_in,       // 0:zone1b 1:zone2b 2:analog_input_first 3:ain2
  input  wire logic [151:0] sample_in,    // Converter result per slot, 19 bytes
  output mesm_result_t      result_out
);
  initial if (CONV_CYCLES < 2 || 64'(CONV_CYCLES) * 21 >=
      64'(`MESM_PASS_MS) * 1000 * `MESM_CLK_MHZ)
    $error("mesm_sequencer: conversion time cannot fit a pass");
  // Slots: 0 internal,1 z1a,2 z1b,3 z2a,4 z2b,5..20 analog 1..16
  logic [4:0]  slot_ff;     // Current slot
  logic [31:0] cnt_ff;      // Conversion timer
  mesm_seq_t   st_ff;       // Sequencer state
  logic [4:0]  nxt_slot;

  // Skip unselected slots
  function automatic logic skip(input logic [4:0] s, input logic [3:0] sel);
    skip = (s == 5'h02 && !sel[0]) || (s == 5'h04 && !sel[1]) ||
           (s == 5'h05 && !sel[2]) || (s == 5'h06 && !sel[3]);
  endfunction

  always_comb
  begin
    nxt_slot = (slot_ff == 5'h14) ? 5'h00 : slot_ff + 5'h01;
    // Zone 2b, analog 1 and analog 2 may all be off: up to three skips
    for (int i = 0; i < 3; i++)
    begin
      if (skip(nxt_slot, sel_in))
      begin
        nxt_slot = nxt_slot + 5'h01;
      end
    end
  end

  // Starts on its own after reset and loops forever [RULE1] [RULE2]
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_ff      <= MESM_IDLE;
      slot_ff    <= 5'h00;
      cnt_ff     <= 32'h0;
      result_out <= '0;
    end
    else
    begin
      result_out.valid <= 1'b0;
      case (st_ff)
        MESM_IDLE:
        begin
          cnt_ff <= 32'h0;
          st_ff  <= MESM_CONV;
        end
        MESM_CONV:
        begin
          cnt_ff <= cnt_ff + 32'h1;
          if (cnt_ff == 32'(CONV_CYCLES - 2))
          begin
            st_ff <= MESM_POST;
          end
        end
        MESM_POST:
        begin
          // Temperature slots map to zone order, analog to channels 5..20
          result_out.valid <= 1'b1;
          result_out.chan  <= slot_ff;
          result_out.data  <= (slot_ff == 5'h00) ? sample_in[7:0] :
                              sample_in[8*(slot_ff - (slot_ff > 5'h02 ? 5'h02 : 5'h00)) +: 8];
          slot_ff <= nxt_slot;
          cnt_ff  <= 32'h0;
          st_ff   <= MESM_CONV;
        end
        default:
        begin
          st_ff <= MESM_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== logic/mesm_top.sv ====
// Error status, masking and alert logic of the hardware monitor
`timescale 1ns/10ps
`include "mesm_defs.svh"
// What this block does
// [RULE1] Monitor from reset, pass under 100 ms
// [RULE2] Fixed conversion order, optional channels skipped
// [RULE3] Results readable in value registers anytime
// [RULE4] Two status banks: management and host
// [RULE5] Status bits sticky until software clears
// [RULE6] Write one clears if event inactive
// [RULE7] Clearing one bank leaves other alone
// [RULE8] Mode bit makes management status read-clear; here only the low word, not the fixed throttle bits
// [RULE9] Masked events never set status bits
// [RULE10] Masking keeps already set bits
// [RULE11] Voltage high limit FFh masks voltage
// [RULE12] Temperature limit 80h masks temperature, diode
// [RULE13] Input mask bits suppress input errors
// [RULE14] User throttle limit FFh masks user bit
// [RULE15] Fixed throttle bits unmaskable, never alert
// [RULE16] Tach limit FFh masks tach errors
// [RULE17] Regulator-hot and inputs have mask bits
// [RULE18] Alert disabled until enable bit set
// [RULE19] Software writes sleep state register
// [RULE20] Sleep state masks fixed or optional events
// [RULE21] External reset loads deepest sleep after 10 us
// [RULE22] Alert follows enabled unmasked status bits
module mesm_top
  import mesm_pkg::*;
#(
  parameter int CONV_CYCLES = 40000,   // Cycles per conversion slot
  parameter int EXTRST_CYC  = `MESM_EXTRST_US * `MESM_CLK_MHZ
)
(
  input  wire logic         clk_sys_in,
  input  wire logic         resetn_in,         // Power-on reset
  input  wire logic         ext_resetn_in,     // External reset input, low active
  input  wire logic [7:0]   addr_in,
  input  wire logic [31:0]  wdata_in,
  input  wire logic         wr_in,
  input  wire logic         rd_in,
  output logic      [31:0]  rdata_out,
  input  wire logic [151:0] sample_in,         // Converter results
  input  wire logic [7:0]   volt_evt_in,       // Voltage over limit, channels 0..7
  input  wire logic [3:0]   temp_evt_in,       // Temperature over limit
  input  wire logic [3:0]   diode_evt_in,      // Diode fault
  input  wire logic [3:0]   tach_evt_in,       // Tach under limit
  input  wire logic [7:0]   gpi_evt_in,        // General input events
  input  wire logic [1:0]   regulator_hot_input,
  input  wire logic [1:0]   processor_throttle_signal,
  input  wire logic         user_throttle_in,  // Throttling past user limit
  output logic              mgmt_error_output,
  output logic              host_err_out,
  output logic              alert_n_out,       // Open-drain alert, low active
  output logic              alert_oe_n_out     // Low while pin driven
);
  // Refuse timings that the 16-bit reset timer or the sequencer cannot hold
  initial
  begin
    if (EXTRST_CYC < 1 || EXTRST_CYC > 65535 || CONV_CYCLES < 2)
    begin
      $error("mesm_top: bad parameters");
    end
  end

  // Error word: [7:0] volt [11:8] temp [15:12] diode [19:16] tach
  // [27:20] gpi, [29:28] reg hot, [30] user thr; hi word [1:0] fixed thr
  logic [31:0] evt;          // Raw events, one bit each
  logic [31:0] mask;         // Combined mask
  logic [31:0] mst_ff;       // Management status bank
  logic [31:0] hst_ff;       // Host status bank
  logic [1:0]  thr_m_ff;     // Fixed throttle bits, management
  logic [1:0]  thr_h_ff;     // Fixed throttle bits, host
  logic        alert_en_ff;  // Alert enable
  logic        asf_ff;       // Read-to-clear mode
  logic [2:0]  sleep_ff;     // Sleep state
  logic [7:0]  slpmsk_ff;    // Optional sleep masks
  logic [7:0]  gpimsk_ff;    // Input masks
  logic [7:0]  miscmsk_ff;   // Regulator-hot masks in [1:0]
  // Limit and value storage
  logic [7:0]  vlim_ff [8];  // Voltage high limits
  logic [7:0]  tlim_ff [4];  // Temperature high limits
  logic [7:0]  flim_ff [4];  // Tach limits
  logic [7:0]  usrlim_ff;    // User throttle limit
  logic [3:0]  chsel_ff;     // Optional channel select
  logic [7:0]  value_ff [21];// Value registers
  logic [15:0] ext_cnt_ff;   // External reset timer
  logic        ext_done_ff;  // Timer fired for this assertion
  mesm_result_t res;
  logic        wsel_m, wsel_h, rclr_m;

  // Sequencer restarts on power-on reset only; the external reset leaves it
  mesm_sequencer #(.CONV_CYCLES(CONV_CYCLES)) u_seq
  (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .sel_in     (chsel_ff),
    .sample_in  (sample_in),
    .result_out (res)
  );

  // No reset here: a value reads unknown until the first pass reaches it
  // Store each posted result [RULE3]
  always_ff @(posedge clk_sys_in)
  begin
    if (res.valid)
    begin
      value_ff[res.chan] <= res.data;
    end
  end

  // Events in status bit order; the spare top bit is always masked
  assign evt = {1'b0, user_throttle_in, regulator_hot_input, gpi_evt_in, tach_evt_in,
                diode_evt_in, temp_evt_in, volt_evt_in};

  // Sleep masks: deep states always hide voltage and tach; optional mask
  // bits hide temp, gpi, regulator-hot in any nonzero state [RULE20]
  // An awake system (state 0) never hides anything through sleep
  function automatic logic [31:0] sleep_mask(input logic [2:0] s, input logic [7:0] m);
    sleep_mask = '0;
    if (s >= 3'h3)
    begin
      sleep_mask[7:0]   = 8'hff;
      sleep_mask[19:16] = 4'hf;
    end
    if (s != 3'h0)
    begin
      sleep_mask[15:8]  = m[0] ? 8'hff : 8'h00;
      sleep_mask[27:20] = m[1] ? 8'hff : 8'h00;
      sleep_mask[29:28] = m[2] ? 2'h3 : 2'h0;
    end
  endfunction

  always_comb
  begin
    // Sleep, limits at masking values and mask registers combine by OR
    mask = sleep_mask(sleep_ff, slpmsk_ff);
    for (int i = 0; i < 8; i++)
    begin
      mask[i] = mask[i] | (vlim_ff[i] == `MESM_VMASK);       // [RULE11]
    end
    for (int i = 0; i < 4; i++)
    begin
      mask[8+i]  = mask[8+i]  | (tlim_ff[i] == `MESM_TMASK); // [RULE12]
      mask[12+i] = mask[12+i] | (tlim_ff[i] == `MESM_TMASK); // [RULE12]
      mask[16+i] = mask[16+i] | (flim_ff[i] == `MESM_FMASK); // [RULE16]
    end
    mask[27:20] = mask[27:20] | gpimsk_ff;                   // [RULE13] [RULE17]
    mask[29:28] = mask[29:28] | miscmsk_ff[1:0];             // [RULE17]
    mask[30]    = usrlim_ff == `MESM_VMASK;                  // [RULE14]
    mask[31]    = 1'b1;
  end

  // Clear strobes; only the low word of each bank takes event bits
  assign wsel_m = wr_in && addr_in == `MESM_A_MST_LO;
  assign wsel_h = wr_in && addr_in == `MESM_A_HST_LO;
  assign rclr_m = rd_in && asf_ff && addr_in == `MESM_A_MST_LO;

  // Management bank: sticky, set beats clear, unmasked only [RULE4] [RULE5] [RULE9] [RULE10]
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mst_ff <= 32'h0;
    end
    else
    begin
      // Clear needs inactive event; read clears in mode [RULE6] [RULE8]
      // A clear that meets a live event is lost: software retries later
      mst_ff <= (mst_ff & ~(((wsel_m ? wdata_in : 32'h0) | (rclr_m ? 32'hffffffff : 32'h0))
                & ~evt)) | (evt & ~mask);
    end
  end

  // Host bank; independent of management clears [RULE4] [RULE7]
  // Reads never clear here, whatever the read-clear mode says
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      hst_ff <= 32'h0;
    end
    else
    begin
      hst_ff <= (hst_ff & ~((wsel_h ? wdata_in : 32'h0) & ~evt)) | (evt & ~mask); // [RULE6]
    end
  end

  // Fixed throttle bits: no mask at all [RULE15]
  // They stick and clear by write like the others but feed only the read port
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      thr_m_ff <= 2'h0;
      thr_h_ff <= 2'h0;
    end
    else
    begin
      thr_m_ff <= (thr_m_ff & ~(((wr_in && addr_in == `MESM_A_MST_HI) ? wdata_in[1:0] : 2'h0)
                  & ~processor_throttle_signal)) | processor_throttle_signal;
      thr_h_ff <= (thr_h_ff & ~(((wr_in && addr_in == `MESM_A_HST_HI) ? wdata_in[1:0] : 2'h0)
                  & ~processor_throttle_signal)) | processor_throttle_signal;
    end
  end

  // External reset timer loads deepest sleep [RULE21]
  // Counts only while the pin stays low; a short pulse loads nothing
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ext_cnt_ff  <= 16'h0;
      ext_done_ff <= 1'b0;
    end
    else if (ext_resetn_in)
    begin
      ext_cnt_ff  <= 16'h0;
      ext_done_ff <= 1'b0;
    end
    else if (!ext_done_ff)
    begin
      ext_cnt_ff  <= ext_cnt_ff + 16'h1;
      ext_done_ff <= ext_cnt_ff == 16'(EXTRST_CYC - 1);
    end
  end

  // Setup and mask registers; limits default to masking values
  // Limit writes carry the channel index above the value byte
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      alert_en_ff <= 1'b0;                    // [RULE18]
      asf_ff      <= 1'b0;
      slpmsk_ff   <= 8'h00;
      gpimsk_ff   <= 8'h00;
      miscmsk_ff  <= 8'h00;
      usrlim_ff   <= `MESM_VMASK;
      chsel_ff    <= 4'hf;
      // Limits start masked, so voltage, temperature, diode, tach and user events stay masked before setup
      for (int i = 0; i < 8; i++)
      begin
        vlim_ff[i] <= `MESM_VMASK;            // [RULE11]
      end
      for (int i = 0; i < 4; i++)
      begin
        tlim_ff[i] <= `MESM_TMASK;            // [RULE12]
        flim_ff[i] <= `MESM_FMASK;            // [RULE16]
      end
    end
    else if (wr_in)
    begin
      case (addr_in)
        `MESM_A_CFG:     alert_en_ff <= wdata_in[`MESM_B_ALERT_EN]; // [RULE18]
        `MESM_A_STCTL:   asf_ff      <= wdata_in[`MESM_B_ASF];
        `MESM_A_SLPMSK:  slpmsk_ff   <= wdata_in[7:0];
        `MESM_A_GPIMSK:  gpimsk_ff   <= wdata_in[7:0];
        `MESM_A_MISCMSK: miscmsk_ff  <= wdata_in[7:0];
        `MESM_A_USRLIM:  usrlim_ff   <= wdata_in[7:0];
        `MESM_A_CHSEL:   chsel_ff    <= wdata_in[3:0];
        `MESM_A_VLIM:    vlim_ff[wdata_in[10:8]] <= wdata_in[7:0];
        `MESM_A_TLIM:    tlim_ff[wdata_in[9:8]]  <= wdata_in[7:0];
        `MESM_A_TACHLIM: flim_ff[wdata_in[9:8]]  <= wdata_in[7:0];
        default:         ;
      endcase
    end
  end

  // Sleep state: power-on reset gives the awake state, then software or ext reset
  // The timer load wins over a software write in the same cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sleep_ff <= `MESM_SLEEP_RST;
    end
    else if (!ext_resetn_in && !ext_done_ff && ext_cnt_ff == 16'(EXTRST_CYC - 1))
    begin
      sleep_ff <= `MESM_SLEEP_DEEP;            // [RULE21]
    end
    else if (wr_in && addr_in == `MESM_A_SLEEP)
    begin
      sleep_ff <= wdata_in[2:0];               // [RULE19]
    end
  end

  // Read port, one cycle later; unmapped reads zero
  // No side effect here; the read-clear sits in the bank logic
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata_out <= 32'h0;
    end
    else
    begin
      rdata_out <= 32'h0;
      if (rd_in)
      begin
        case (addr_in)
          `MESM_A_CFG:     rdata_out <= {31'h0, alert_en_ff};
          `MESM_A_STCTL:   rdata_out <= {31'h0, asf_ff};
          `MESM_A_SLEEP:   rdata_out <= {29'h0, sleep_ff};
          `MESM_A_SLPMSK:  rdata_out <= {24'h0, slpmsk_ff};
          `MESM_A_GPIMSK:  rdata_out <= {24'h0, gpimsk_ff};
          `MESM_A_MISCMSK: rdata_out <= {24'h0, miscmsk_ff};
          `MESM_A_USRLIM:  rdata_out <= {24'h0, usrlim_ff};
          `MESM_A_CHSEL:   rdata_out <= {28'h0, chsel_ff};
          `MESM_A_MST_LO:  rdata_out <= mst_ff;
          `MESM_A_MST_HI:  rdata_out <= {30'h0, thr_m_ff};
          `MESM_A_HST_LO:  rdata_out <= hst_ff;
          `MESM_A_HST_HI:  rdata_out <= {30'h0, thr_h_ff};
          default:
          begin
            // Value registers from 80h, one word per slot [RULE3]
            if (addr_in >= `MESM_A_VALUE && addr_in[7:2] < 6'h35 && addr_in[1:0] == 2'h0)
            begin
              rdata_out <= {24'h0, value_ff[5'(addr_in[6:2])]};
            end
          end
        endcase
      end
    end
  end

  // Error and alert outputs; fixed throttle bits excluded [RULE15] [RULE22]
  // Pin level stays low and only the enable moves, so the line never
  // sees a short glitch when the alert starts
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mgmt_error_output <= 1'b0;
      host_err_out      <= 1'b0;
      alert_n_out       <= 1'b1;
      alert_oe_n_out    <= 1'b1;
    end
    else
    begin
      mgmt_error_output <= |mst_ff;
      host_err_out      <= |hst_ff;
      alert_n_out       <= 1'b0;
      alert_oe_n_out    <= !(alert_en_ff && (|mst_ff || |hst_ff)); // [RULE18] [RULE22]
    end
  end
endmodule

// ==== dv/mesm_top_assertions.sv ====
// Checker for the register bus, error outputs and alert of the monitor
`timescale 1ns/10ps
`include "mesm_defs.svh"
module mesm_top_checker
(
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [7:0]  volt_evt_in,
  input wire logic [3:0]  temp_evt_in,
  input wire logic [3:0]  diode_evt_in,
  input wire logic [3:0]  tach_evt_in,
  input wire logic [7:0]  gpi_evt_in,
  input wire logic [1:0]  regulator_hot_input,
  input wire logic        user_throttle_in,
  input wire logic        mgmt_error_output,
  input wire logic        host_err_out,
  input wire logic        alert_oe_n_out
);
  logic cfg_seen_ff; // Alert enable written since reset
  logic lo_any;      // Some event that may feed the low status word
  logic clr_m;       // Access that may clear management bits
  logic clr_h;       // Write that may clear host bits
  // Fixed throttle inputs are left out on purpose: they never reach the error or alert outputs
  assign lo_any = |{user_throttle_in, regulator_hot_input, gpi_evt_in,
                    tach_evt_in, diode_evt_in, temp_evt_in, volt_evt_in};
  assign clr_m = (wr_in || rd_in) && addr_in == `MESM_A_MST_LO;
  assign clr_h = wr_in && addr_in == `MESM_A_HST_LO;
  // Remember the first write that sets the alert enable
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      cfg_seen_ff <= 1'b0;
    else if (wr_in && addr_in == `MESM_A_CFG && wdata_in[`MESM_B_ALERT_EN])
      cfg_seen_ff <= 1'b1;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  a_read_idle: assert property (
    !$past(rd_in) |-> rdata_out == 32'h0) else $error("read data outside answer cycle");
  a_unmapped_zero: assert property (
    rd_in && addr_in == 8'hfc |=> rdata_out == 32'h0) else $error("unmapped read not zero");
  a_mgmt_cause: assert property (
    $rose(mgmt_error_output) |-> $past(lo_any, 2)) else $error("mgmt error without event");
  a_host_cause: assert property (
    $rose(host_err_out) |-> $past(lo_any, 2)) else $error("host error without event");
  a_mgmt_sticky: assert property (
    $fell(mgmt_error_output) |-> $past(clr_m, 2)) else $error("mgmt error dropped alone");
  a_host_sticky: assert property (
    $fell(host_err_out) |-> $past(clr_h, 2)) else $error("host error dropped alone");
  a_alert_gate: assert property (
    !alert_oe_n_out |-> mgmt_error_output || host_err_out) else $error("alert without status");
  a_alert_enable: assert property (
    !cfg_seen_ff |-> alert_oe_n_out) else $error("alert driven before enable");
endmodule
bind mesm_top mesm_top_checker i_chk (.clk_sys_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .volt_evt_in, .temp_evt_in, .diode_evt_in, .tach_evt_in, .gpi_evt_in,
  .regulator_hot_input, .user_throttle_in, .mgmt_error_output, .host_err_out,
  .alert_oe_n_out);

// ==== dv/mesm_host_model.sv ====
// Register bus master standing in for the management controller and host
`timescale 1ns/10ps
module mesm_host_model
(
  input  wire logic        clk_sys_in,
  input  wire logic [31:0] rdata_in,
  output logic      [7:0]  addr_out,
  output logic      [31:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out
);
  // Idle bus at time zero
  initial
  begin
    addr_out = 8'h0;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One-cycle write; ones written to status clear bits
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_out <= 1'b0;
    addr_out <= ~a; // Stale address changes so it cannot be relied on
    wdata_out <= ~d;
  endtask
  // One-cycle read; data taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1 d = rdata_in;
  endtask
endmodule

// ==== dv/monitor_error_status_masking_tb.sv ====
// Self-checking bench for the monitor error status and masking block
`timescale 1ns/10ps
`include "mesm_defs.svh"
module monitor_error_status_masking_tb;
  import mesm_pkg::*;
  // One table row: setup write, event pulse, expected status words
  typedef struct packed
  {
    logic [7:0]  a;
    logic [31:0] d;
    logic [32:0] ev;
    logic [31:0] lo;
    logic [1:0]  hi;
  } mesm_row_t;
  logic         clk_sys_in;    // System clock
  logic         resetn_in;     // Power-on reset
  logic         ext_resetn_in; // External reset
  logic [7:0]   addr;
  logic [31:0]  wdata;
  logic         wr;
  logic         rd;
  logic [31:0]  rdata;
  logic [151:0] sample;        // Converter bytes, byte k holds 10h+k
  logic [32:0]  evt;           // {throttle, user, reg hot, gpi, tach, diode, temp, volt}
  logic         mgmt_err;
  logic         host_err;
  logic         alert_n;
  logic         alert_oe_n;
  logic [31:0]  v;
  int           bad_count;
  int           n_tests;
  // Later rows rely on limits and masks left by earlier ones
  mesm_row_t rows [0:13] = '{
    '{`MESM_A_CHSEL, 32'hf, 33'h10_0000, 32'h10_0000, 2'h0},
    '{`MESM_A_CFG, 32'h1, 33'h1, 32'h0, 2'h0},
    '{`MESM_A_VLIM, 32'h10, 33'h1, 32'h1, 2'h0},
    '{`MESM_A_CHSEL, 32'hf, 33'h1100, 32'h0, 2'h0},
    '{`MESM_A_TLIM, 32'h50, 33'h1100, 32'h1100, 2'h0},
    '{`MESM_A_TACHLIM, 32'hff, 33'h1_0000, 32'h0, 2'h0},
    '{`MESM_A_TACHLIM, 32'h40, 33'h1_0000, 32'h1_0000, 2'h0},
    '{`MESM_A_GPIMSK, 32'h1, 33'h30_0000, 32'h20_0000, 2'h0},
    '{`MESM_A_MISCMSK, 32'h1, 33'h3000_0000, 32'h2000_0000, 2'h0},
    '{`MESM_A_USRLIM, 32'hff, 33'h4000_0000, 32'h0, 2'h0},
    '{`MESM_A_USRLIM, 32'h50, 33'h4000_0000, 32'h4000_0000, 2'h0},
    '{`MESM_A_SLEEP, 32'h3, 33'h1_0001, 32'h0, 2'h0},
    '{`MESM_A_SLPMSK, 32'h1, 33'h100, 32'h0, 2'h0},
    '{`MESM_A_SLEEP, 32'h0, 33'h1_8000_0000, 32'h0, 2'h3}};
  mesm_top #(.CONV_CYCLES(4), .EXTRST_CYC(5)) i_dut (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .ext_resetn_in(ext_resetn_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sample_in(sample), .volt_evt_in(evt[7:0]),
    .temp_evt_in(evt[11:8]), .diode_evt_in(evt[15:12]), .tach_evt_in(evt[19:16]),
    .gpi_evt_in(evt[27:20]), .regulator_hot_input(evt[29:28]), .user_throttle_in(evt[30]),
    .processor_throttle_signal(evt[32:31]), .mgmt_error_output(mgmt_err),
    .host_err_out(host_err), .alert_n_out(alert_n), .alert_oe_n_out(alert_oe_n));
  mesm_host_model i_host (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  // 100 MHz clock
  always #5 clk_sys_in = ~clk_sys_in;
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One-cycle event, then room for status and outputs to settle
  task automatic pulse(input logic [32:0] e);
    @(posedge clk_sys_in);
    evt <= e;
    @(posedge clk_sys_in);
    evt <= '0;
    repeat (3) @(posedge clk_sys_in);
  endtask
  // Write ones to every status word of both banks
  task automatic clr_all;
    i_host.wr(`MESM_A_MST_LO, 32'hffff_ffff);
    i_host.wr(`MESM_A_HST_LO, 32'hffff_ffff);
    i_host.wr(`MESM_A_MST_HI, 32'hffff_ffff);
    i_host.wr(`MESM_A_HST_HI, 32'hffff_ffff);
    repeat (3) @(posedge clk_sys_in);
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Guard against a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    bad_count++;
    summarize();
  end
  // Main sequence
  initial
  begin
    clk_sys_in = 1'b0;
    resetn_in = 1'b0;
    ext_resetn_in = 1'b1;
    evt = '0;
    bad_count = 0;
    n_tests = 0;
    for (int k = 0; k < 19; k++)
      sample[k*8 +: 8] = 8'(8'h10 + k);
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    #1 chk("oe_reset", {31'h0, alert_oe_n}, 32'h1);
    chk("alert_n_rst", {31'h0, alert_n}, 32'h1);
    i_host.rd(`MESM_A_CFG, v); chk("cfg", v, 32'h0);
    i_host.rd(`MESM_A_CHSEL, v); chk("chsel", v, 32'hf);
    i_host.rd(`MESM_A_SLEEP, v); chk("sleep", v, 32'h0);
    i_host.rd(8'hfc, v); chk("unmapped", v, 32'h0);
    // Table: masks, limits and sleep states against each event kind
    for (int i = 0; i < 14; i++)
    begin
      i_host.wr(rows[i].a, rows[i].d);
      pulse(rows[i].ev);
      #1 chk("mgmt_err", {31'h0, mgmt_err}, {31'h0, |rows[i].lo});
      chk("host_err", {31'h0, host_err}, {31'h0, |rows[i].lo});
      chk("alert_oe", {31'h0, alert_oe_n}, {31'h0, !(i > 0 && |rows[i].lo)});
      chk("alert_n", {31'h0, alert_n}, 32'h0);
      i_host.rd(`MESM_A_MST_LO, v); chk("mst_lo", v, rows[i].lo);
      i_host.rd(`MESM_A_HST_LO, v); chk("hst_lo", v, rows[i].lo);
      i_host.rd(`MESM_A_MST_HI, v); chk("mst_hi", v, {30'h0, rows[i].hi});
      i_host.rd(`MESM_A_HST_HI, v); chk("hst_hi", v, {30'h0, rows[i].hi});
      clr_all();
      #1 chk("mgmt_clr", {31'h0, mgmt_err}, 32'h0);
      chk("oe_clr", {31'h0, alert_oe_n}, 32'h1);
    end
    // Clear refused while the event is still high
    @(posedge clk_sys_in);
    evt <= 33'h40_0000;
    i_host.wr(`MESM_A_MST_LO, 32'hffff_ffff);
    i_host.rd(`MESM_A_MST_LO, v); chk("clr_busy", v, 32'h40_0000);
    @(posedge clk_sys_in);
    evt <= '0;
    clr_all();
    i_host.rd(`MESM_A_MST_LO, v); chk("clr_done", v, 32'h0);
    // Banks clear independently, both ways
    pulse(33'h80_0000);
    i_host.wr(`MESM_A_MST_LO, 32'h80_0000);
    i_host.rd(`MESM_A_HST_LO, v); chk("hst_kept", v, 32'h80_0000);
    pulse(33'h80_0000);
    i_host.wr(`MESM_A_HST_LO, 32'h80_0000);
    i_host.rd(`MESM_A_MST_LO, v); chk("mst_kept", v, 32'h80_0000);
    clr_all();
    // Read-clear mode hits the management bank only
    i_host.wr(`MESM_A_STCTL, 32'h1);
    pulse(33'h100_0000);
    i_host.rd(`MESM_A_MST_LO, v); chk("rc_first", v, 32'h100_0000);
    i_host.rd(`MESM_A_MST_LO, v); chk("rc_again", v, 32'h0);
    i_host.rd(`MESM_A_HST_LO, v); chk("hst_rc1", v, 32'h100_0000);
    i_host.rd(`MESM_A_HST_LO, v); chk("hst_rc2", v, 32'h100_0000);
    i_host.wr(`MESM_A_STCTL, 32'h0);
    clr_all();
    // Masking afterwards keeps a set bit, then blocks new ones
    pulse(33'h200_0000);
    i_host.wr(`MESM_A_GPIMSK, 32'h21);
    i_host.rd(`MESM_A_MST_LO, v); chk("mask_keep", v, 32'h200_0000);
    clr_all();
    pulse(33'h200_0000);
    i_host.rd(`MESM_A_MST_LO, v); chk("mask_block", v, 32'h0);
    // External reset loads the deepest sleep state
    @(posedge clk_sys_in);
    ext_resetn_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    ext_resetn_in <= 1'b1;
    i_host.rd(`MESM_A_SLEEP, v); chk("sleep_ext", v, {29'h0, `MESM_SLEEP_DEEP});
    i_host.wr(`MESM_A_SLEEP, 32'h0);
    // Results posted without any request
    i_host.rd(`MESM_A_VALUE, v); chk("value0", v, 32'h10);
    i_host.rd(`MESM_A_VALUE + 8'h4, v); chk("value1", v, 32'h11);
    summarize();
  end
endmodule
